// ---- fpm_lane_filter.sv ----
// Purpose: Applies denormals-as-zero to a source and flush-to-zero to a result.
// Assumes: Single precision sits in the low 32 bits when dbl is low.
// Notes: Purely combinational; the result sign is the unrounded sign from the datapath.
`timescale 1ns/1ps
`default_nettype none
module fpm_lane_filter
  import fpm_pkg::*;
(
  fpm_lane_if.lane lane_if
);
  logic src_denorm;
  // ==========================================================================
  // Denormal detection: zero exponent with a nonzero fraction, per format.
  always_comb begin
    if (lane_if.dbl) begin
      src_denorm = (lane_if.src[62:52] == 11'h000) && (lane_if.src[51:0] != 52'h0);
    end else begin
      src_denorm = (lane_if.src[30:23] == 8'h00) && (lane_if.src[22:0] != 23'h0);
    end
  end
  // One shared mode pair governs both precisions. [RL10]
  always_comb begin
    lane_if.src_flt = lane_if.src;
    if (lane_if.denormals_as_zero && src_denorm) begin
      // Keep the sign, clear everything else. [RL2] [RL4]
      lane_if.src_flt = lane_if.dbl ? {lane_if.src[63], 63'h0} :
                        {32'h0, lane_if.src[31], 31'h0};
    end
  end
  always_comb begin
    lane_if.res_flt = lane_if.res;
    if (lane_if.flush_underflow_to_zero && lane_if.res_uflow) begin
      // Underflow collapses to a signed zero. [RL1]
      lane_if.res_flt = lane_if.dbl ? {lane_if.res[63], 63'h0} :
                        {32'h0, lane_if.res[31], 31'h0};
    end
    // With both modes off, values pass untouched for the IEEE datapath. [RL3]
  end
endmodule
`default_nettype wire

// ---- fpm_lane_if.sv ----
// Purpose: Carrier between the control unit and its SIMD lane filter.
// Assumes: Same clock domain on both sides.
// Notes: Mode bits flow down; filtered values flow up.
`timescale 1ns/1ps
`default_nettype none
interface fpm_lane_if;
  logic flush_underflow_to_zero;
  logic denormals_as_zero;
  logic dbl;
  logic [63:0] src;
  logic [63:0] src_flt;
  logic [63:0] res;
  logic res_uflow;
  logic [63:0] res_flt;
  modport ctrl (output flush_underflow_to_zero, denormals_as_zero, dbl, src, res, res_uflow, input src_flt, res_flt);
  modport lane (input flush_underflow_to_zero, denormals_as_zero, dbl, src, res, res_uflow, output src_flt, res_flt);
endinterface
`default_nettype wire

// ---- fpm_mode_ctrl.sv ----
// Purpose: Floating-point mode control: control words, load paths and lane modes.
// Assumes: Instruction strobes come from core logic on clk_in; no pin inputs.
// Notes: busy_out stalls issue while a slow or serializing operation runs.
// Behaviour
// [RL1] With flush mode on, an underflowing SIMD result becomes a zero of the unrounded sign.
// [RL2] With denormals-as-zero on, denormal SIMD sources are read as signed zeros.
// [RL3] With both modes off, underflows and denormals pass to the IEEE datapath unchanged.
// [RL4] Denormals-as-zero applies to instructions of both SIMD generations.
// [RL5] Legacy word holds precision in bits 8-9, rounding in 10-11, infinity in bit 12.
// [RL6] Alternating between two values differing only in bits 8-12 takes the fast path.
// [RL7] A load changing any bit outside bits 8-12 takes the slow path.
// [RL8] Cycling among three or more values makes every load slow.
// [RL9] A SIMD word write serializes, a read is slow, and no fast path exists.
// [RL10] Single and double SIMD operations share one mode word.
// [RL11] A masked SIMD overflow is handled with no penalty.
// [RL12] Legacy intermediates use extended range for overflow and underflow checks.
// [RL13] Truncating integer store ignores the rounding field and the control word.
// [RL14] Single precision lets the divider finish early.
// [RL15] Software stores and reloads the legacy word with 16-bit accesses.
// [RL16] After reset both SIMD non-standard modes are off.
`timescale 1ns/1ps
`default_nettype none
module fpm_mode_ctrl
  import fpm_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic fcw_load_in,
  input wire logic [15:0] fcw_load_data_in,
  output logic [15:0] legacy_fp_control_word_out,
  output logic [1:0] precision_control_field_out,
  output logic [1:0] rounding_control_out,
  output logic infinity_control_out,
  output logic fcw_fast_out,
  input wire logic scw_write_in,
  input wire logic [31:0] scw_write_data_in,
  input wire logic scw_read_in,
  output logic [31:0] scw_read_data_out,
  output logic scw_read_valid_out,
  output logic flush_underflow_to_zero_out,
  output logic denormals_as_zero_out,
  output logic busy_out,
  input wire logic div_start_in,
  output logic div_done_out,
  input wire logic lane_dbl_in,
  input wire logic [63:0] lane_src_in,
  input wire logic [63:0] lane_res_in,
  input wire logic lane_res_uflow_in,
  input wire logic lane_ovf_masked_in,
  output logic [63:0] lane_src_out,
  output logic [63:0] lane_res_out,
  output logic lane_stall_out,
  input wire logic [79:0] ext_result_in,
  output logic ext_overflow_out,
  output logic ext_underflow_out,
  input wire logic trunc_store_in,
  input wire logic [1:0] trunc_width_in,
  input wire logic [63:0] trunc_value_in,
  output logic [63:0] trunc_result_out
);
  typedef enum logic [1:0] {FPM_IDLE, FPM_SLOW, FPM_SERIAL, FPM_SCW_READ} fpm_state_t;
  // ==========================================================================
  // State record. Every register of the unit lives in one packed struct so
  // that reset and the clocked update stay in one place.
  //   state, wait_cnt: the penalty sequencer; wait_cnt counts down to one.
  //   fcw, fcw_prev: the live legacy word and the last distinct word before
  //     it; the pair is what the two-value fast path compares against.
  //   scw, scw_rd, scw_rd_valid: the SIMD word, its read-back copy and the
  //     one-cycle pulse that marks the copy as fresh.
  //   fast: level that tells whether the last legacy load took the fast path.
  //   div_cnt, div_busy, div_done: the divider latency model.
  //   src_q, res_q: filtered lane values, one cycle behind the lane inputs.
  //   trunc_q: the last truncating-store result, held until the next store.
  //   ext_ovf, ext_unf: range flags of the last extended intermediate.
  // Only two words are remembered for the fast path. A program that cycles
  // among three or more words therefore never finds a match and pays the
  // full penalty on every load, which is the intended cost model.
  typedef struct packed {
    fpm_state_t state;
    logic [4:0] wait_cnt;
    logic [15:0] legacy_fp_control_word;
    logic [15:0] fcw_prev;
    logic [31:0] scw;
    logic [31:0] scw_rd;
    logic scw_rd_valid;
    logic fast;
    logic [4:0] div_cnt;
    logic div_busy;
    logic div_done;
    logic [63:0] src_q;
    logic [63:0] res_q;
    logic [63:0] trunc_q;
    logic ext_ovf;
    logic ext_unf;
  } fpm_regs_t;
  fpm_regs_t state_reg;
  fpm_regs_t state_next;
  fpm_lane_if lane_bus ();
  logic fast_hit;
  logic [14:0] ext_exp;
  // ==========================================================================
  // Lane filter wiring.
  assign lane_bus.flush_underflow_to_zero = state_reg.scw[FPM_FTZ_BIT];
  assign lane_bus.denormals_as_zero = state_reg.scw[FPM_DAZ_BIT];
  assign lane_bus.dbl = lane_dbl_in;
  assign lane_bus.src = lane_src_in;
  assign lane_bus.res = lane_res_in;
  assign lane_bus.res_uflow = lane_res_uflow_in;
  fpm_lane_filter u_lane (
    .lane_if(lane_bus)
  );
  // ==========================================================================
  // A load is fast only if it matches the current word outside bits 8-12
  // and equals the current word or the one value seen just before, i.e. a two-value alternation.
  assign fast_hit = (((fcw_load_data_in ^ state_reg.legacy_fp_control_word) & ~FPM_FAST_MASK) == 16'h0000) &&
                    (fcw_load_data_in == state_reg.fcw_prev ||
                     fcw_load_data_in == state_reg.legacy_fp_control_word); // [RL6] [RL7] [RL8]
  assign ext_exp = ext_result_in[78:64];
  // ==========================================================================
  // Next-state logic.
  always_comb begin
    state_next = state_reg;
    state_next.scw_rd_valid = 1'b0;
    state_next.div_done = 1'b0;
    state_next.src_q = lane_bus.src_flt;
    state_next.res_q = lane_bus.res_flt;
    // Extended-range checks on legacy intermediates: an all-ones exponent with zero
    // fraction is overflow to infinity, zero exponent with nonzero mantissa is underflow. [RL12]
    state_next.ext_ovf = (ext_exp == 15'h7fff) && (ext_result_in[62:0] == 63'h0);
    state_next.ext_unf = (ext_exp == 15'h0000) && (ext_result_in[63:0] != 64'h0);
    case (state_reg.state)
      FPM_IDLE: begin
        if (fcw_load_in) begin
          state_next.legacy_fp_control_word = fcw_load_data_in; // [RL5]
          if (fcw_load_data_in != state_reg.legacy_fp_control_word) begin
            state_next.fcw_prev = state_reg.legacy_fp_control_word;
          end
          state_next.fast = fast_hit;
          if (!fast_hit) begin
            state_next.state = FPM_SLOW; // [RL7] [RL8]
            state_next.wait_cnt = FPM_SLOW_CYCLES;
          end
        end else if (scw_write_in) begin
          state_next.scw = scw_write_data_in; // [RL9]
          state_next.state = FPM_SERIAL;
          state_next.wait_cnt = FPM_SERIAL_CYCLES;
        end else if (scw_read_in) begin
          state_next.state = FPM_SCW_READ; // [RL9]
          state_next.wait_cnt = FPM_SCW_READ_CYCLES;
        end
      end
      FPM_SLOW, FPM_SERIAL, FPM_SCW_READ: begin
        if (state_reg.wait_cnt == 5'h01) begin
          if (state_reg.state == FPM_SCW_READ) begin
            state_next.scw_rd = state_reg.scw;
            state_next.scw_rd_valid = 1'b1;
          end
          state_next.state = FPM_IDLE;
          state_next.wait_cnt = 5'h00;
        end else begin
          state_next.wait_cnt = state_reg.wait_cnt - 5'h01;
        end
      end
      default: begin
        state_next.state = FPM_IDLE;
      end
    endcase
    // A start that arrives while the divider still counts is ignored; the
    // model holds one division at a time.
    // Divider latency follows the precision field; single finishes early. [RL14]
    if (div_start_in && !state_reg.div_busy) begin
      state_next.div_busy = 1'b1;
      case (state_reg.legacy_fp_control_word[FPM_PREC_LSB +: 2])
        FPM_PREC_SINGLE: state_next.div_cnt = FPM_DIV_SINGLE_CYCLES;
        2'h2: state_next.div_cnt = FPM_DIV_DOUBLE_CYCLES;
        default: state_next.div_cnt = FPM_DIV_EXT_CYCLES;
      endcase
    end else if (state_reg.div_busy) begin
      if (state_reg.div_cnt == 5'h01) begin
        state_next.div_busy = 1'b0;
        state_next.div_done = 1'b1;
      end
      state_next.div_cnt = state_reg.div_cnt - 5'h01;
    end
    // Truncation to the chosen width, never consulting the rounding field. [RL13]
    if (trunc_store_in) begin
      case (trunc_width_in)
        FPM_INT16: state_next.trunc_q = {{48{trunc_value_in[15]}}, trunc_value_in[15:0]};
        FPM_INT32: state_next.trunc_q = {{32{trunc_value_in[31]}}, trunc_value_in[31:0]};
        default: state_next.trunc_q = trunc_value_in;
      endcase
    end
  end
  // ==========================================================================
  // State register; both SIMD modes come up off. [RL16]
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg <= '0;
      state_reg.state <= FPM_IDLE;
      state_reg.legacy_fp_control_word <= FPM_FCW_RESET;
      state_reg.fcw_prev <= FPM_FCW_RESET;
      state_reg.scw <= FPM_SCW_RESET;
    end else begin
      state_reg <= state_next;
    end
  end
  // ==========================================================================
  // Outputs. Masked overflow never stalls the lane. [RL11]
  assign lane_stall_out = 1'b0 & lane_ovf_masked_in;
  assign legacy_fp_control_word_out = state_reg.legacy_fp_control_word;
  assign precision_control_field_out = state_reg.legacy_fp_control_word[FPM_PREC_LSB +: 2]; // [RL5]
  assign rounding_control_out = state_reg.legacy_fp_control_word[FPM_ROUND_LSB +: 2];
  assign infinity_control_out = state_reg.legacy_fp_control_word[FPM_INF_BIT];
  assign fcw_fast_out = state_reg.fast;
  assign scw_read_data_out = state_reg.scw_rd;
  assign scw_read_valid_out = state_reg.scw_rd_valid;
  assign flush_underflow_to_zero_out = state_reg.scw[FPM_FTZ_BIT];
  assign denormals_as_zero_out = state_reg.scw[FPM_DAZ_BIT];
  // Busy covers every penalty state. Legacy loads and SIMD word writes and reads offered while it is high are
  // dropped without notice, so issue logic must hold them until it falls.
  assign busy_out = (state_reg.state != FPM_IDLE);
  assign div_done_out = state_reg.div_done;
  assign lane_src_out = state_reg.src_q;
  assign lane_res_out = state_reg.res_q;
  assign ext_overflow_out = state_reg.ext_ovf;
  assign ext_underflow_out = state_reg.ext_unf;
  assign trunc_result_out = state_reg.trunc_q;
endmodule
`default_nettype wire

// ---- fpm_mode_ctrl_properties.sv ----
// Purpose: Concurrent checks on the ports of the floating-point mode control unit.
// Assumes: One clock, asynchronous active-high reset.
// Notes: Bound to the top module with a bind after the module.
`timescale 1ns/1ps
`default_nettype none
module fpm_mode_ctrl_properties
  import fpm_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic fcw_load_in,
  input wire logic [15:0] fcw_load_data_in,
  input wire logic [15:0] legacy_fp_control_word_out,
  input wire logic [1:0] precision_control_field_out,
  input wire logic [1:0] rounding_control_out,
  input wire logic infinity_control_out,
  input wire logic scw_write_in,
  input wire logic scw_read_in,
  input wire logic scw_read_valid_out,
  input wire logic busy_out,
  input wire logic div_start_in,
  input wire logic div_done_out,
  input wire logic lane_ovf_masked_in,
  input wire logic lane_stall_out,
  input wire logic trunc_store_in,
  input wire logic [1:0] trunc_width_in,
  input wire logic [63:0] trunc_value_in,
  input wire logic [63:0] trunc_result_out
);
  // ==========================================================================
  // Properties
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // A legacy word load is only taken while the unit is idle.
  logic ld_ok;
  assign ld_ok = fcw_load_in && !busy_out;
  prec_field_a: assert property (precision_control_field_out == legacy_fp_control_word_out[9:8] &&
    rounding_control_out == legacy_fp_control_word_out[11:10])
    else $error("control fields do not follow the legacy word");
  inf_field_a: assert property (infinity_control_out == legacy_fp_control_word_out[12])
    else $error("infinity field does not follow the legacy word");
  load_update_a: assert property (ld_ok |=> legacy_fp_control_word_out == $past(fcw_load_data_in))
    else $error("legacy word not loaded");
  slow_load_a: assert property (ld_ok && ((fcw_load_data_in ^ legacy_fp_control_word_out) &
    ~FPM_FAST_MASK) != 16'h0000 |=> busy_out[*8])
    else $error("load outside fast bits did not stall");
  scw_serial_a: assert property (scw_write_in && !busy_out && !fcw_load_in |=> busy_out[*8])
    else $error("control status write did not serialize");
  scw_read_a: assert property (scw_read_in && !busy_out && !fcw_load_in && !scw_write_in
    |=> !scw_read_valid_out[*8] ##1 scw_read_valid_out)
    else $error("control status read latency wrong");
  div_early_a: assert property (div_start_in && precision_control_field_out == FPM_PREC_SINGLE
    |-> ##11 div_done_out)
    else $error("single precision divide not early");
  ovf_free_a: assert property (lane_ovf_masked_in && !busy_out && !fcw_load_in && !scw_write_in &&
    !scw_read_in |=> !busy_out && !lane_stall_out)
    else $error("masked overflow stalled the lane");
  trunc_16_a: assert property (trunc_store_in && trunc_width_in == 2'h0 |=>
    trunc_result_out == {{48{$past(trunc_value_in[15])}}, $past(trunc_value_in[15:0])})
    else $error("16-bit truncating store wrong");
  cover_slow_c: cover property (ld_ok ##1 busy_out);
  cover_read_c: cover property (scw_read_valid_out);
  cover_div_c: cover property (div_done_out);
endmodule
bind fpm_mode_ctrl fpm_mode_ctrl_properties fpm_mode_ctrl_properties_inst (.*);
`default_nettype wire

// ---- fpm_pkg.sv ----
// Purpose: Shared constants and types for the floating-point mode control unit.
// Assumes: One core clock, asynchronous active-high reset.
// Notes: Field positions of the legacy control word and the SIMD control word.
package fpm_pkg;
  // ==========================================================================
  // Legacy control word layout
  localparam int FPM_PREC_LSB = 8;
  localparam int FPM_ROUND_LSB = 10;
  localparam int FPM_INF_BIT = 12;
  localparam logic [15:0] FPM_FAST_MASK = 16'h1f00;
  localparam logic [15:0] FPM_FCW_RESET = 16'h037f;
  localparam logic [1:0] FPM_PREC_SINGLE = 2'h0;
  localparam logic [1:0] FPM_ROUND_TRUNC = 2'h3;
  // ==========================================================================
  // SIMD control word layout and reset value (both modes off)
  localparam int FPM_DAZ_BIT = 6;
  localparam int FPM_FTZ_BIT = 15;
  localparam logic [31:0] FPM_SCW_RESET = 32'h00001f80;
  // ==========================================================================
  // Penalty cycle counts
  localparam logic [4:0] FPM_SLOW_CYCLES = 5'h14;
  localparam logic [4:0] FPM_SERIAL_CYCLES = 5'h14;
  localparam logic [4:0] FPM_SCW_READ_CYCLES = 5'h08;
  localparam logic [4:0] FPM_DIV_SINGLE_CYCLES = 5'h0a;
  localparam logic [4:0] FPM_DIV_DOUBLE_CYCLES = 5'h11;
  localparam logic [4:0] FPM_DIV_EXT_CYCLES = 5'h15;
  // Operation codes of the datapath.
  typedef enum logic [1:0] {FPM_OP_ADD, FPM_OP_MUL, FPM_OP_PASS} fpm_op_t;
  // Integer widths for the truncating store.
  typedef enum logic [1:0] {FPM_INT16, FPM_INT32, FPM_INT64} fpm_int_t;
endpackage

// ---- test_fpm_mode_ctrl.sv ----
// Purpose: Self-checking bench for the floating-point mode control unit.
// Assumes: Inputs change at the falling edge; one request at a time.
// Notes: Covers load paths, the SIMD word, lane modes, divider and truncation.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module test_fpm_mode_ctrl;
  import fpm_pkg::*;
  logic clk_in = 0, sys_rst_in = 1, fcw_load_in = 0, scw_write_in = 0, scw_read_in = 0;
  logic div_start_in = 0, lane_dbl_in = 0, lane_res_uflow_in = 0, lane_ovf_masked_in = 0;
  logic trunc_store_in = 0, fcw_fast_out, scw_read_valid_out, busy_out, div_done_out;
  logic flush_underflow_to_zero_out, denormals_as_zero_out, infinity_control_out;
  logic [1:0] precision_control_field_out, rounding_control_out, trunc_width_in = 0;
  logic [15:0] fcw_load_data_in = 0, legacy_fp_control_word_out;
  logic [31:0] scw_write_data_in = 0, scw_read_data_out;
  logic [63:0] lane_src_in = 0, lane_res_in = 0, trunc_value_in = 0;
  logic [63:0] lane_src_out, lane_res_out, trunc_result_out;
  logic lane_stall_out, ext_overflow_out, ext_underflow_out;
  logic [79:0] ext_result_in = 0;
  int fails = 0, check_count = 0;
  fpm_mode_ctrl fpm_mode_ctrl_inst (.*);
  // ==========================================================================
  // Clock, verdict and watchdog.
  initial begin
    forever #2 clk_in = ~clk_in;
  end
  task give_verdict;
    if (fails == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // The span is over thirty times what the sequence below needs.
  initial begin
    #40000;
    fails++;
    give_verdict();
  end
  // ==========================================================================
  // Access tasks; ld and wr wait bounded for the unit to go idle again.
  task idle;
    int i;
    i = 0;
    while (busy_out !== 1'b0 && i < 40) begin @(negedge clk_in); i++; end
  endtask
  task ld(input logic [15:0] d, input logic f);
    @(negedge clk_in) fcw_load_in = 1; fcw_load_data_in = d;
    @(negedge clk_in) fcw_load_in = 0;
    `CHK(legacy_fp_control_word_out, d)
    `CHK(fcw_fast_out, f)
    `CHK(busy_out, !f)
    idle();
  endtask
  task wr(input logic [31:0] d);
    @(negedge clk_in) scw_write_in = 1; scw_write_data_in = d;
    @(negedge clk_in) scw_write_in = 0;
    `CHK(busy_out, 1'b1)
    idle();
    `CHK({flush_underflow_to_zero_out, denormals_as_zero_out}, {d[15], d[6]})
  endtask
  // Counts edges from the taking edge to the answer pulse.
  task pulse_wait(input int want, input logic is_div);
    int n;
    n = 0;
    while ((is_div ? div_done_out : scw_read_valid_out) !== 1'b1 && n < 40) begin
      @(negedge clk_in); n++;
    end
    `CHK(n, want)
  endtask
  task div(input int want);
    @(negedge clk_in) div_start_in = 1;
    @(negedge clk_in) div_start_in = 0;
    pulse_wait(want, 1);
  endtask
  task lane(input logic dbl, input logic [63:0] s, r, input logic uf, input logic [63:0] es, er);
    @(negedge clk_in) lane_dbl_in = dbl; lane_src_in = s; lane_res_in = r; lane_res_uflow_in = uf;
    @(negedge clk_in);
    `CHK(lane_src_out, es)
    `CHK(lane_res_out, er)
  endtask
  task tr(input logic [1:0] w, input logic [63:0] v, e);
    @(negedge clk_in) trunc_store_in = 1; trunc_width_in = w; trunc_value_in = v;
    @(negedge clk_in) trunc_store_in = 0;
    `CHK(trunc_result_out, e)
  endtask
  // ==========================================================================
  // Main sequence.
  initial begin
    repeat (10) @(negedge clk_in);
    sys_rst_in = 0;
    `CHK({flush_underflow_to_zero_out, denormals_as_zero_out}, 2'b00)
    `CHK(rounding_control_out, 2'h0)
    // The first new word has no partner word yet, so it pays the penalty.
    ld(16'h0f7f, 0);
    `CHK(rounding_control_out, FPM_ROUND_TRUNC)
    ld(16'h037f, 1);
    ld(16'h0f7f, 1);
    ld(16'h1f7f, 0);
    ld(16'h037f, 0);
    `CHK(infinity_control_out, 1'b0)
    ld(16'h037e, 0);
    ld(16'h007f, 0);
    `CHK(precision_control_field_out, FPM_PREC_SINGLE)
    div(10);
    ld(16'h027f, 0);
    div(17);
    ld(16'h037f, 0);
    div(21);
    wr(32'h00009fc0);
    @(negedge clk_in) scw_read_in = 1;
    @(negedge clk_in) scw_read_in = 0;
    pulse_wait(8, 0);
    `CHK(scw_read_data_out, 32'h00009fc0)
    lane_ovf_masked_in = 1;
    lane(0, 64'h0000_0000_8000_0001, 64'h0000_0000_8000_0123, 1,
      64'h0000_0000_8000_0000, 64'h0000_0000_8000_0000);
    lane(1, 64'h800f_0000_0000_0001, 64'h8000_0000_0000_0123, 1,
      64'h8000_0000_0000_0000, 64'h8000_0000_0000_0000);
    `CHK(lane_stall_out, 1'b0)
    lane_ovf_masked_in = 0;
    // A reset in mid-run must drop both SIMD modes that were just switched on.
    @(negedge clk_in) sys_rst_in = 1;
    @(negedge clk_in) sys_rst_in = 0;
    `CHK({flush_underflow_to_zero_out, denormals_as_zero_out}, 2'b00)
    `CHK(legacy_fp_control_word_out, FPM_FCW_RESET)
    wr(FPM_SCW_RESET);
    lane(1, 64'h800f_0000_0000_0001, 64'h8000_0000_0000_0123, 1,
      64'h800f_0000_0000_0001, 64'h8000_0000_0000_0123);
    tr(2'h0, 64'h0000_0000_0001_8001, 64'hffff_ffff_ffff_8001);
    tr(2'h1, 64'h0000_0001_8000_0000, 64'hffff_ffff_8000_0000);
    tr(2'h2, 64'h8000_0000_0000_0005, 64'h8000_0000_0000_0005);
    // Extended intermediates: an all-ones exponent overflows, a zero one underflows.
    @(negedge clk_in) ext_result_in = 80'h7fff_8000_0000_0000_0000;
    @(negedge clk_in) ext_result_in = 80'h0000_0000_0000_0000_0001;
    `CHK({ext_overflow_out, ext_underflow_out}, 2'b10)
    @(negedge clk_in) ext_result_in = 80'h0;
    `CHK({ext_overflow_out, ext_underflow_out}, 2'b01)
    give_verdict();
  end
endmodule
`default_nettype wire
